// ---- timer_channel_regs.svh ----
// Register offsets, field positions, reset values and bus codes for the timer channels
`ifndef TIMER_CHANNEL_REGS_SVH
`define TIMER_CHANNEL_REGS_SVH

// ----------------------------------------------------------------
// Byte addresses on the register bus
// ----------------------------------------------------------------
`define TCC_ADDR_W        8
`define TCC_CH_STRIDE     8'h0C
`define TCC_SC_OFFSET     8'h00
`define TCC_VH_OFFSET     8'h04
`define TCC_VL_OFFSET     8'h08

// ----------------------------------------------------------------
// Status/control field positions
// ----------------------------------------------------------------
`define TCC_SC_FLAG_BIT   7
`define TCC_SC_IE_BIT     6
`define TCC_SC_MSB_BIT    5
`define TCC_SC_MSA_BIT    4
`define TCC_SC_ELSB_BIT   3
`define TCC_SC_ELSA_BIT   2
`define TCC_SC_TOV_BIT    1
`define TCC_SC_MAX_BIT    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCC_SC_RESET      8'h00
`define TCC_VAL_RESET     16'h0000
`define TCC_CNT_RESET     16'h0000

// ----------------------------------------------------------------
// Bus answer codes
// ----------------------------------------------------------------
`define TCC_RESP_OKAY     2'h0
`define TCC_RESP_SLVERR   2'h2

`endif

// ---- timer_channel_pkg.sv ----
// Types shared by the timer channel capture/compare logic
package timer_channel_pkg;

	// ----------------------------------------------------------------
	// One channel's status/control byte, bit 7 first
	// ----------------------------------------------------------------
	typedef struct packed {
		logic chan_event_flag;
		logic chan_irq_enable;
		logic buffered_select;
		logic mode_select_a;
		logic edge_level_hi;
		logic edge_level_lo;
		logic toggle_on_wrap;
		logic full_duty_force;
	} chan_ctrl_t;

	// ----------------------------------------------------------------
	// Pin action on a compare match, from the edge/level pair
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ACT_NONE,
		ACT_TOGGLE,
		ACT_CLEAR,
		ACT_SET
	} pin_action_t;

	// ----------------------------------------------------------------
	// Pin drive pair carried together
	// ----------------------------------------------------------------
	typedef struct packed {
		logic level;
		logic enable;
	} pin_drive_t;

endpackage

// ---- timer_channel_capture_compare.sv ----
// Two-channel capture/compare/PWM logic with an AXI4-Lite register slave
//
// Overview of operation
// RQ1: Capture mode sets the event flag on the selected active pin edge.
// RQ2: Compare mode sets the event flag when counter equals channel value.
// RQ3: Flag clears by read-while-set then write 0; newer event voids it.
// RQ4: Interrupt request asserts only while enable and flag are both one.
// RQ5: Channel 0 buffered bit disables channel 1 control and frees its pin.
// RQ6: Nonzero edge/level, unbuffered: mode bit A picks compare or capture.
// RQ7: Edge/level zero: port owns pin; mode bit A presets level low/high; code presets high for A=0, low for A=1.
// RQ8: Capture trigger: 01 rising, 10 falling, 11 either edge.
// RQ9: Unbuffered compare action: 00 flag only, 01 toggle, 10 clear, 11 set.
// RQ10: Buffered compare action: 01 toggle, 10 clear, 11 set.
// RQ11: Edge/level zero disconnects pin; channel holds preset level meanwhile.
// RQ12: Toggle-on-wrap toggles pin on each wrap in compare mode only.
// RQ13: Wrap toggle wins over a compare action in the same count.
// RQ14: Full-duty bit with toggle and clear forces 100 percent from next period.
// RQ15: Value register holds captured count or compare value; reset value arbitrary.
// RQ16: Capture mode: reading high byte blocks captures until low byte read.
// RQ17: Compare mode: writing high byte blocks matches until low byte written.
// RQ18: Reset clears flag, enable, mode bits, edge/level bits and toggle bit.
// RQ19: Software should halt and clear the counter before changing mode bits.
// RQ20: Pin should be steady two clocks before capture is enabled.
// RQ21: Captures are suppressed while the counter halt bit is set.
// RQ22: A wrap is signalled when the counter reaches the modulo value.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "timer_channel_regs.svh"

module timer_channel_capture_compare #(
	parameter int NUM_CHAN = 2
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr_in,
	input  wire logic        awvalid_in,
	output logic             awready_out,
	input  wire logic [31:0] wdata_in,
	input  wire logic [3:0]  wstrb_in,
	input  wire logic        wvalid_in,
	output logic             wready_out,
	// AXI4-Lite write response
	output logic [1:0]       bresp_out,
	output logic             bvalid_out,
	input  wire logic        bready_in,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr_in,
	input  wire logic        arvalid_in,
	output logic             arready_out,
	output logic [31:0]      rdata_out,
	output logic [1:0]       rresp_out,
	output logic             rvalid_out,
	input  wire logic        rready_in,
	// Shared counter, same clock
	input  wire logic [15:0] counter_value_in,
	input  wire logic [15:0] modulo_value_in,
	input  wire logic        counter_halt_in,
	// Channel pins
	input  wire logic [1:0]  channel_pin_in,
	output logic [1:0]       channel_pin_out,
	output logic [1:0]       channel_pin_oe_out,
	// Per-channel interrupt requests
	output logic [1:0]       chan_irq_out
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	// Buffering pairs channel 0 with channel 1, so exactly two are served
	if (NUM_CHAN != 2) begin : g_bad_chan
		$error("timer_channel_capture_compare supports NUM_CHAN == 2 only");
	end

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	logic                       awready_r;
	logic                       wready_r;
	logic                       aw_held_r;
	logic                       w_held_r;
	logic [7:0]                 aw_addr_r;
	logic [31:0]                w_data_r;
	logic [3:0]                 w_strb_r;
	logic                       bvalid_r;
	logic [1:0]                 bresp_r;
	logic                       arready_r;
	logic                       rvalid_r;
	logic [31:0]                rdata_r;
	logic [1:0]                 rresp_r;
	logic                       wr_fire;
	logic                       rd_fire;
	logic                       wr_hit;
	logic                       rd_hit;
	logic [7:0]                 rd_byte;

	// Per-channel decode strobes and exported state
	logic [1:0]                 wr_sc;
	logic [1:0]                 wr_vh;
	logic [1:0]                 wr_vl;
	logic [1:0]                 rd_sc;
	logic [1:0]                 rd_vh;
	logic [1:0]                 rd_vl;
	timer_channel_pkg::chan_ctrl_t ctrl_w [2];
	logic [15:0]                val_w  [2];

	// Counter tracking
	logic [15:0]                cnt_prev_r;
	logic                       new_count;
	logic                       wrap;

	// Write takes effect once both halves are held and no answer is pending
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign rd_fire = arvalid_in && arready_r;

	// ----------------------------------------------------------------
	// Write address, data and response channels
	// ----------------------------------------------------------------
	// Ready stays low from acceptance until the response is taken
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `TCC_RESP_OKAY;
		end else begin
			if (awvalid_in && awready_r) begin
				aw_addr_r <= awaddr_in;
				aw_held_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (wvalid_in && wready_r) begin
				w_data_r <= wdata_in;
				w_strb_r <= wstrb_in;
				w_held_r <= 1'b1;
				wready_r <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
			end
			if (bvalid_r && bready_in) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read address and data channels
	// ----------------------------------------------------------------
	// Data is captured at acceptance, so read side effects happen then
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `TCC_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= {24'h000000, rd_byte};
				rresp_r   <= rd_hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
			end
			if (rvalid_r && rready_in) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign awready_out = awready_r;
	assign wready_out  = wready_r;
	assign bvalid_out  = bvalid_r;
	assign bresp_out   = bresp_r;
	assign arready_out = arready_r;
	assign rvalid_out  = rvalid_r;
	assign rdata_out   = rdata_r;
	assign rresp_out   = rresp_r;

	// ----------------------------------------------------------------
	// Address decode and read mux
	// ----------------------------------------------------------------
	// Only byte lane 0 carries register data; other lanes are ignored
	always_comb begin
		wr_hit  = 1'b0;
		rd_hit  = 1'b0;
		rd_byte = 8'h00;
		wr_sc   = 2'b00;
		wr_vh   = 2'b00;
		wr_vl   = 2'b00;
		rd_sc   = 2'b00;
		rd_vh   = 2'b00;
		rd_vl   = 2'b00;
		for (int c = 0; c < 2; c++) begin
			if (aw_addr_r == 8'(c) * `TCC_CH_STRIDE + `TCC_SC_OFFSET) begin
				wr_hit   = 1'b1;
				wr_sc[c] = wr_fire && w_strb_r[0];
			end
			if (aw_addr_r == 8'(c) * `TCC_CH_STRIDE + `TCC_VH_OFFSET) begin
				wr_hit   = 1'b1;
				wr_vh[c] = wr_fire && w_strb_r[0];
			end
			if (aw_addr_r == 8'(c) * `TCC_CH_STRIDE + `TCC_VL_OFFSET) begin
				wr_hit   = 1'b1;
				wr_vl[c] = wr_fire && w_strb_r[0];
			end
			if (araddr_in == 8'(c) * `TCC_CH_STRIDE + `TCC_SC_OFFSET) begin
				rd_hit   = 1'b1;
				rd_byte  = ctrl_w[c];
				rd_sc[c] = rd_fire;
			end
			if (araddr_in == 8'(c) * `TCC_CH_STRIDE + `TCC_VH_OFFSET) begin
				rd_hit   = 1'b1;
				rd_byte  = val_w[c][15:8];
				rd_vh[c] = rd_fire;
			end
			if (araddr_in == 8'(c) * `TCC_CH_STRIDE + `TCC_VL_OFFSET) begin
				rd_hit   = 1'b1;
				rd_byte  = val_w[c][7:0];
				rd_vl[c] = rd_fire;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter step and wrap detection
	// ----------------------------------------------------------------
	// The counter is prescaled; act once per new count, not once per clock
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_prev_r <= `TCC_CNT_RESET;
		end else begin
			cnt_prev_r <= counter_value_in;
		end
	end

	assign new_count = counter_value_in != cnt_prev_r;
	assign wrap      = new_count && (counter_value_in == modulo_value_in); // RQ22

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_chan
		timer_channel_pkg::chan_ctrl_t  ctrl_r;
		timer_channel_pkg::pin_action_t action;
		timer_channel_pkg::pin_drive_t  drive_r;
		logic [15:0]                    val_r;
		logic [15:0]                    target;
		logic                           armed_r;
		logic                           rd_lock_r;
		logic                           wr_lock_r;
		logic                           max_eff_r;
		logic                           irq_r;
		logic                           sync1_r;
		logic                           sync2_r;
		logic                           sync3_r;
		logic                           disabled;
		logic                           buffered;
		logic                           els_zero;
		logic                           compare_mode;
		logic                           capture_mode;
		logic                           edge_hit;
		logic                           capture_ev;
		logic                           match;
		logic                           chan_event;

		// Mode decode from the mode and edge/level bits
		assign disabled     = (g == 1) && ctrl_w[0].buffered_select; // RQ5
		assign buffered     = (g == 0) && ctrl_r.buffered_select;
		assign els_zero     = !ctrl_r.edge_level_hi && !ctrl_r.edge_level_lo;
		assign compare_mode = !disabled && (ctrl_r.mode_select_a || buffered); // RQ6
		assign capture_mode = !disabled && !ctrl_r.mode_select_a && !buffered
				&& !els_zero; // RQ6

		// Pin action on compare from the edge/level pair
		always_comb begin
			case ({ctrl_r.edge_level_hi, ctrl_r.edge_level_lo})
				2'b01:   action = timer_channel_pkg::ACT_TOGGLE; // RQ9 RQ10
				2'b10:   action = timer_channel_pkg::ACT_CLEAR; // RQ9 RQ10
				2'b11:   action = timer_channel_pkg::ACT_SET; // RQ9 RQ10
				default: action = timer_channel_pkg::ACT_NONE; // RQ9
			endcase
		end

		// Pin synchroniser; third stage only keeps history for edges
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				sync1_r <= 1'b0;
				sync2_r <= 1'b0;
				sync3_r <= 1'b0;
			end else begin
				sync1_r <= channel_pin_in[g];
				sync2_r <= sync1_r;
				sync3_r <= sync2_r;
			end
		end

		// Active edge select
		assign edge_hit = (ctrl_r.edge_level_lo && sync2_r && !sync3_r)
				|| (ctrl_r.edge_level_hi && !sync2_r && sync3_r); // RQ8
		assign capture_ev = capture_mode && edge_hit && !counter_halt_in
				&& !rd_lock_r; // RQ1 RQ16 RQ21

		// Buffered compare takes the channel value whose low byte was written last, loaded at each wrap
		if (g == 0) begin : g_buf
			logic        buf_src_r;
			logic [15:0] act_cmp_r;
			always_ff @(posedge clk_sys_in or posedge rst_in) begin
				if (rst_in) begin
					buf_src_r <= 1'b0;
					act_cmp_r <= `TCC_VAL_RESET;
				end else begin
					if (wr_vl[1])
						buf_src_r <= 1'b1;
					else if (wr_vl[0])
						buf_src_r <= 1'b0;
					if (wrap)
						act_cmp_r <= buf_src_r ? val_w[1] : val_w[0]; // RQ10
				end
			end
			assign target = buffered ? act_cmp_r : val_r;
		end else begin : g_unbuf
			assign target = val_r;
		end

		assign match = compare_mode && new_count && (counter_value_in == target)
				&& !wr_lock_r; // RQ2 RQ17
		assign chan_event = match || capture_ev;

		// Control byte and flag; a new event always beats a clear
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				ctrl_r  <= `TCC_SC_RESET; // RQ18
				armed_r <= 1'b0;
			end else begin
				if (rd_sc[g] && ctrl_r.chan_event_flag && !disabled)
					armed_r <= 1'b1; // RQ3
				if (wr_sc[g] && !disabled) begin // RQ5
					ctrl_r.chan_irq_enable <= w_data_r[`TCC_SC_IE_BIT];
					ctrl_r.buffered_select <= (g == 0) && w_data_r[`TCC_SC_MSB_BIT];
					ctrl_r.mode_select_a   <= w_data_r[`TCC_SC_MSA_BIT];
					ctrl_r.edge_level_hi   <= w_data_r[`TCC_SC_ELSB_BIT];
					ctrl_r.edge_level_lo   <= w_data_r[`TCC_SC_ELSA_BIT];
					ctrl_r.toggle_on_wrap  <= w_data_r[`TCC_SC_TOV_BIT];
					ctrl_r.full_duty_force <= w_data_r[`TCC_SC_MAX_BIT];
					if (armed_r && !w_data_r[`TCC_SC_FLAG_BIT])
						ctrl_r.chan_event_flag <= 1'b0; // RQ3
					armed_r <= 1'b0;
				end
				if (chan_event) begin
					ctrl_r.chan_event_flag <= 1'b1; // RQ1 RQ2 RQ3
					armed_r                <= 1'b0; // RQ3
				end
			end
		end

		// Value register; a capture outranks a same-cycle byte write
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				val_r <= `TCC_VAL_RESET; // RQ15
			end else if (capture_ev) begin
				val_r <= counter_value_in; // RQ15
			end else begin
				if (wr_vh[g])
					val_r[15:8] <= w_data_r[7:0];
				if (wr_vl[g])
					val_r[7:0] <= w_data_r[7:0];
			end
		end

		// Byte coherency interlocks, dropped when the mode leaves
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				rd_lock_r <= 1'b0;
				wr_lock_r <= 1'b0;
			end else begin
				if (!capture_mode)
					rd_lock_r <= 1'b0;
				else if (rd_vh[g])
					rd_lock_r <= 1'b1; // RQ16
				else if (rd_vl[g])
					rd_lock_r <= 1'b0; // RQ16
				if (!compare_mode)
					wr_lock_r <= 1'b0;
				else if (wr_vh[g])
					wr_lock_r <= 1'b1; // RQ17
				else if (wr_vl[g])
					wr_lock_r <= 1'b0; // RQ17
			end
		end

		// Full duty only changes at a wrap, so a period is never cut short
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				max_eff_r <= 1'b0;
			end else if (wrap) begin
				max_eff_r <= ctrl_r.full_duty_force && ctrl_r.toggle_on_wrap
						&& (action == timer_channel_pkg::ACT_CLEAR); // RQ14
			end
		end

		// Pin drive; port owns the pin whenever edge/level is zero
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				drive_r <= '{level: 1'b1, enable: 1'b0};
			end else if (disabled) begin
				drive_r.enable <= 1'b0; // RQ5
			end else if (els_zero) begin
				drive_r.enable <= 1'b0; // RQ11
				drive_r.level  <= !ctrl_r.mode_select_a; // RQ7 RQ11
			end else if (!compare_mode) begin
				drive_r.enable <= 1'b0;
			end else begin
				drive_r.enable <= 1'b1; // RQ11
				if (wrap && ctrl_r.toggle_on_wrap) begin // RQ12 RQ13
					drive_r.level <= max_eff_r ? 1'b1 : !drive_r.level; // RQ14
				end else if (match) begin
					case (action)
						timer_channel_pkg::ACT_TOGGLE: drive_r.level <= !drive_r.level;
						timer_channel_pkg::ACT_CLEAR:  drive_r.level <= max_eff_r; // RQ14
						timer_channel_pkg::ACT_SET:    drive_r.level <= 1'b1;
						default:                       drive_r.level <= drive_r.level;
					endcase
				end
			end
		end

		// Interrupt request
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				irq_r <= 1'b0;
			end else begin
				irq_r <= ctrl_r.chan_irq_enable && ctrl_r.chan_event_flag
						&& !disabled; // RQ4
			end
		end

		assign ctrl_w[g]             = ctrl_r;
		assign val_w[g]              = val_r;
		assign channel_pin_out[g]    = drive_r.level;
		assign channel_pin_oe_out[g] = drive_r.enable;
		assign chan_irq_out[g]       = irq_r;
	end

endmodule // timer_channel_capture_compare

// ---- tcc_pin_model.sv ----
// External pin source that shares the channel pins with the timer
`timescale 1ns/1ps

module tcc_pin_model (
	// Levels the outside world wants on each pin
	input  wire logic [1:0] level_in,
	// Timer drive side
	input  wire logic [1:0] drv_in,
	input  wire logic [1:0] oe_in,
	// Resolved wire level
	output logic      [1:0] pin_out
);
	// Timer wins where it drives; the source level reaches the pin wherever the timer does not drive
	assign pin_out = (oe_in & drv_in) | (~oe_in & level_in);
endmodule // tcc_pin_model

// ---- timer_channel_capture_compare_asserts.sv ----
// Port-level checks for the timer channel block
`timescale 1ns/1ps

module timer_channel_capture_compare_asserts (
	// Clock and reset
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	// Register bus
	input wire logic        awvalid_in,
	input wire logic        awready_out,
	input wire logic        wvalid_in,
	input wire logic        wready_out,
	input wire logic        bvalid_out,
	input wire logic [7:0]  araddr_in,
	input wire logic        arvalid_in,
	input wire logic        arready_out,
	input wire logic [31:0] rdata_out,
	input wire logic [1:0]  rresp_out,
	input wire logic        rvalid_out,
	// Counter and pins
	input wire logic [15:0] counter_value_in,
	input wire logic [1:0]  channel_pin_out,
	input wire logic [1:0]  chan_irq_out
);
	logic [7:0]  ar_q;
	logic [15:0] cnt_q;
	logic        moved_q;

	// Address of the read in flight, so answers can be judged
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) ar_q <= 8'h00;
		else if (arvalid_in && arready_out) ar_q <= araddr_in;
	end

	// Count change one edge late, lined up with the pin register
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 16'h0000;
			moved_q <= 1'b0;
		end else begin
			cnt_q <= counter_value_in;
			moved_q <= counter_value_in != cnt_q;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_wr_taken;
		awvalid_in && awready_out && wvalid_in && wready_out;
	endsequence
	sequence s_recent_wr;
		$past(bvalid_out) || $past(bvalid_out, 2) || $past(bvalid_out, 3);
	endsequence

	a_b_after_both: assert property (s_wr_taken |=> ##1 bvalid_out)
		else $error("write answer late");
	a_aw_refused: assert property (awvalid_in && awready_out |=> !awready_out)
		else $error("address still open");
	a_ar_answer: assert property (arvalid_in && arready_out |=> !arready_out && rvalid_out)
		else $error("read answer late");
	a_rd_upper: assert property (rvalid_out |-> rdata_out[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_unmapped_err: assert property (rvalid_out && (ar_q > 8'h14 || ar_q[1:0] != 2'h0)
		|-> rresp_out == 2'h2 && rdata_out == 32'h00000000)
		else $error("unmapped read answered");
	a_ch1_no_buf: assert property (rvalid_out && ar_q == 8'h0C |-> !rdata_out[5])
		else $error("buffered bit in channel 1");
	a_irq_drop_wr: assert property ((|($past(chan_irq_out) & ~chan_irq_out)) |-> s_recent_wr)
		else $error("interrupt fell without write");
	a_pin_cause: assert property ($changed(channel_pin_out) |-> (moved_q or s_recent_wr))
		else $error("pin moved without cause");
endmodule // timer_channel_capture_compare_asserts

bind timer_channel_capture_compare timer_channel_capture_compare_asserts chk_u (.*);

// ---- tb_top.sv ----
// Self-checking bench for the timer channel block
`timescale 1ns/1ps

module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [7:0]  awaddr_in = 8'h00, araddr_in = 8'h00;
	logic        awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
	logic        arvalid_in = 1'b0, rready_in = 1'b0, counter_halt_in = 1'b0;
	logic [31:0] wdata_in = 32'h00000000;
	logic [3:0]  wstrb_in = 4'hF;
	logic [15:0] counter_value_in = 16'h0000, modulo_value_in = 16'hFFFF;
	logic [1:0]  ext_lvl = 2'h0;
	logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	logic [1:0]  bresp_out, rresp_out, channel_pin_in, channel_pin_out;
	logic [1:0]  channel_pin_oe_out, chan_irq_out;
	logic [31:0] rdata_out;
	logic [7:0]  rd_d;
	int          err_total = 0, samples_checked = 0;

	// 10 MHz clock
	initial forever #50 clk_sys_in = ~clk_sys_in;

	timer_channel_capture_compare dut_u (.*);
	tcc_pin_model pin_u (.level_in(ext_lvl), .drv_in(channel_pin_out),
		.oe_in(channel_pin_oe_out), .pin_out(channel_pin_in));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// Write one byte; both channels offered together, each released when taken
	task automatic wr(input logic [7:0] a, d);
		int n = 0;
		@(posedge clk_sys_in);
		awaddr_in <= a;
		wdata_in <= {24'h000000, d};
		awvalid_in <= 1'b1;
		wvalid_in <= 1'b1;
		bready_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (awready_out) awvalid_in <= 1'b0;
			if (wready_out) wvalid_in <= 1'b0;
			n++;
		end while (!bvalid_out && n < 50);
		bready_in <= 1'b0;
		chk("bresp", 32'h0, {n >= 50, bresp_out});
	endtask

	// Read one byte and compare it
	task automatic rdc(input string nm, input logic [7:0] a, e, input logic [1:0] re = 2'h0);
		int n = 0;
		@(posedge clk_sys_in);
		araddr_in <= a;
		arvalid_in <= 1'b1;
		rready_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (arready_out) arvalid_in <= 1'b0;
			n++;
		end while (!rvalid_out && n < 50);
		rready_in <= 1'b0;
		rd_d = rdata_out[7:0];
		chk(nm, {n >= 50, re, e}, {1'b0, rresp_out, rd_d});
	endtask

	// Move the counter, then let the event edge and the pin register settle
	task automatic step(input logic [15:0] v);
		@(posedge clk_sys_in);
		counter_value_in <= v;
		repeat (3) @(posedge clk_sys_in);
	endtask

	// Change the external pin level and wait out the synchroniser
	task automatic pin_to(input logic [1:0] v);
		@(posedge clk_sys_in);
		ext_lvl <= v;
		repeat (5) @(posedge clk_sys_in);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdc("ctrl0", 8'h00, 8'h00);
		rdc("ctrl1", 8'h0C, 8'h00);
		rdc("unmapped", 8'h18, 8'h00, 2'h2);
		chk("oe", 32'h0, channel_pin_oe_out);
		chk("irq", 32'h0, chan_irq_out);
		$display("test reset done");
	endtask

	// Each edge select: rise at one count, fall at another
	task automatic t_capture();
		logic [1:0]  els;
		logic [15:0] a_v, e_v;
		for (int i = 1; i < 4; i++) begin
			els = 2'(i);
			a_v = 16'h1A30 + 16'(i);
			e_v = (els == 2'h1) ? a_v : 16'h2B40;
			wr(8'h00, {4'h4, els, 2'h0});
			step(a_v);
			pin_to(2'h1);
			wr(8'h00, {4'h4, els, 2'h0});
			rdc("flag rise", 8'h00, {els[0], 3'h4, els, 2'h0});
			chk("irq0", {31'h0, els[0]}, chan_irq_out[0]);
			wr(8'h00, {4'h4, els, 2'h0});
			step(16'h2B40);
			pin_to(2'h0);
			rdc("cap high", 8'h04, e_v[15:8]);
			rdc("cap low", 8'h08, e_v[7:0]);
			rdc("flag fall", 8'h00, {els[1], 3'h4, els, 2'h0});
		end
		$display("test capture done");
	endtask

	task automatic t_hold();
		wr(8'h00, 8'h04);
		@(posedge clk_sys_in);
		counter_halt_in <= 1'b1;
		step(16'h3C3C);
		pin_to(2'h1);
		rdc("halt flag", 8'h00, 8'h04);
		pin_to(2'h0);
		@(posedge clk_sys_in);
		counter_halt_in <= 1'b0;
		rdc("halt high", 8'h04, 8'h2B);
		step(16'h4D4D);
		pin_to(2'h1);
		rdc("lock low", 8'h08, 8'h40);
		$display("test hold done");
	endtask

	task automatic t_compare();
		logic [7:0] codes [3] = '{8'h14, 8'h18, 8'h1C};
		logic       lvl [3] = '{1'b1, 1'b0, 1'b1};
		@(posedge clk_sys_in);
		counter_halt_in <= 1'b1;
		step(16'h0000);
		wr(8'h0C, 8'h10);
		counter_halt_in <= 1'b0;
		wr(8'h10, 8'h00);
		chk("preset oe", 32'h0, channel_pin_oe_out[1]);
		chk("preset lvl", 32'h0, channel_pin_out[1]);
		wr(8'h14, 8'h50);
		for (int j = 0; j < 3; j++) begin
			wr(8'h0C, codes[j]);
			step(16'h0040);
			step(16'h0050);
			chk("cmp pin", {31'h0, lvl[j]}, channel_pin_out[1]);
			chk("cmp oe", 32'h1, channel_pin_oe_out[1]);
			rdc("cmp flag", 8'h0C, 8'h80 | codes[j]);
		end
		wr(8'h0C, 8'h18);
		wr(8'h10, 8'h00);
		step(16'h0040);
		step(16'h0050);
		chk("locked pin", 32'h1, channel_pin_out[1]);
		wr(8'h14, 8'h50);
		step(16'h0040);
		step(16'h0050);
		chk("unlocked pin", 32'h0, channel_pin_out[1]);
		$display("test compare done");
	endtask

	task automatic t_wrap();
		@(posedge clk_sys_in);
		modulo_value_in <= 16'h0060;
		wr(8'h0C, 8'h1A);
		step(16'h0060);
		chk("wrap pin", 32'h1, channel_pin_out[1]);
		step(16'h0050);
		chk("clear pin", 32'h0, channel_pin_out[1]);
		wr(8'h14, 8'h60);
		step(16'h0010);
		step(16'h0060);
		chk("wrap wins", 32'h1, channel_pin_out[1]);
		wr(8'h0C, 8'h5B);
		repeat (3) begin
			step(16'h0010);
			step(16'h0060);
		end
		chk("full duty", 32'h1, channel_pin_out[1]);
		$display("test wrap done");
	endtask

	task automatic t_buffer();
		logic p;
		wr(8'h00, 8'h34);
		wr(8'h04, 8'h00);
		chk("ch1 oe", 32'h0, channel_pin_oe_out[1]);
		chk("ch1 irq", 32'h0, chan_irq_out[1]);
		wr(8'h0C, 8'h00);
		wr(8'h08, 8'h30);
		step(16'h0010);
		step(16'h0060);
		p = channel_pin_out[0];
		step(16'h0030);
		chk("buf pin", {31'h0, ~p}, channel_pin_out[0]);
		chk("buf oe", 32'h1, channel_pin_oe_out[0]);
		rdc("ch1 ctrl", 8'h0C, 8'hDB);
		$display("test buffer done");
	endtask

	// ----------------------------------------------------------------
	// Sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		t_reset();
		t_capture();
		t_hold();
		t_compare();
		t_wrap();
		t_buffer();
		end_of_test();
	end

	// Run is a few hundred cycles; ten thousand means a hang
	initial begin
		#1000000;
		err_total++;
		end_of_test();
	end
endmodule // tb_top
